// ### logic/dmx_core.sv
// Purpose: Eight-channel transfer core with priority arbitration.
// Assumes: Requests and config come from logic on sys_clk; the dual-port
//          SRAM read port answers in the same cycle.
// Notes:   Channel 0 has the highest priority.
`timescale 1ns/1ps
module dmx_core
    import dmx_pkg::*;
(
    input  wire logic                           sys_clk,
    input  wire logic                           nrst,
    // Per-channel configuration
    input  wire logic [NUM_CHAN-1:0]            chan_enable,
    input  wire logic [NUM_CHAN-1:0]            chan_to_periph,
    input  wire logic [NUM_CHAN-1:0]            chan_periph_indirect,
    input  wire logic [NUM_CHAN-1:0]            chan_use_second,
    input  wire logic [NUM_CHAN-1:0]            chan_force,
    input  wire logic [NUM_CHAN-1:0][SRC_W-1:0] chan_request_select_reg,
    input  wire logic [NUM_CHAN-1:0][ADDR_W-1:0] chan_periph_target_addr,
    input  wire logic [NUM_CHAN-1:0][ADDR_W-1:0] chan_mem_start_first,
    input  wire logic [NUM_CHAN-1:0][ADDR_W-1:0] chan_mem_start_second,
    input  wire logic [NUM_CHAN-1:0][CNT_W-1:0] chan_count_limit,
    // Peripheral requests, indexed by request_source_code
    input  wire logic [NUM_SRC-1:0]             periph_req,
    // Transfer cycle
    output logic                                xfer_active,
    output logic      [CHAN_W-1:0]              xfer_chan,
    output logic      [SRC_W-1:0]               xfer_source,
    input  wire logic [ADDR_W-1:0]              periph_ind_addr,
    output logic                                periph_rd_en,
    output logic      [ADDR_W-1:0]              periph_rd_addr,
    input  wire logic [DATA_W-1:0]              periph_rdata,
    output logic                                sram_rd_en,
    output logic      [ADDR_W-1:0]              sram_rd_addr,
    input  wire logic [DATA_W-1:0]              sram_rdata,
    // Write side, fed from the FIFO
    output logic                                periph_wr_en,
    output logic      [ADDR_W-1:0]              periph_wr_addr,
    output logic      [DATA_W-1:0]              periph_wdata,
    input  wire logic                           periph_wr_ready,
    output logic                                sram_wr_en,
    output logic      [ADDR_W-1:0]              sram_wr_addr,
    output logic      [DATA_W-1:0]              sram_wdata,
    input  wire logic                           sram_wr_ready,
    // Status
    output logic [NUM_CHAN-1:0][CNT_W-1:0]      chan_transfer_count_reg,
    output logic      [NUM_CHAN-1:0]            chan_done_irq,
    output logic      [3:0]                     last_active_channel_field,
    output logic      [NUM_CHAN-1:0]            chan_pending
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Lowest set bit wins: channel 0 has the highest priority
    function automatic logic [CHAN_W-1:0] first_set(
        input logic [NUM_CHAN-1:0] vec
    );
        logic [CHAN_W-1:0] idx;
        idx = '0;
        for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (vec[i]) begin
                idx = CHAN_W'(i);
            end
        end
        return idx;
    endfunction

    // Known peripheral targets; anything else is silently unmapped
    function automatic logic target_known(
        input logic [ADDR_W-1:0] addr,
        input logic              write
    );
        logic rd_ok;
        logic wr_ok;
        rd_ok = (addr == TGT_CAPTURE_ONE)  ||
                (addr == TGT_CAPTURE_TWO)  ||
                (addr == TGT_SERIAL_ONE)   ||
                (addr == TGT_SERIAL_TWO)   ||
                (addr == TGT_UART_ONE_RX)  ||
                (addr == TGT_UART_TWO_RX)  ||
                (addr == TGT_CAN_RX)       ||
                (addr == TGT_CODEC_RX)     ||
                (addr == TGT_CONVERTER)    ||
                (addr == TGT_PARALLEL);
        wr_ok = (addr == TGT_COMPARE_ONE_P) ||
                (addr == TGT_COMPARE_ONE_S) ||
                (addr == TGT_COMPARE_TWO_P) ||
                (addr == TGT_COMPARE_TWO_S) ||
                (addr == TGT_SERIAL_ONE)    ||
                (addr == TGT_SERIAL_TWO)    ||
                (addr == TGT_UART_ONE_TX)   ||
                (addr == TGT_UART_TWO_TX)   ||
                (addr == TGT_CAN_TX)        ||
                (addr == TGT_CODEC_TX)      ||
                (addr == TGT_PARALLEL)      ||
                (addr == TGT_DAC_RIGHT)     ||
                (addr == TGT_DAC_LEFT);
        return write ? wr_ok : rd_ok;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_CHAN-1:0]            pend;
        logic                           act_valid;
        logic [CHAN_W-1:0]              act_chan;
        logic [NUM_CHAN-1:0][CNT_W-1:0] count;
        logic [NUM_CHAN-1:0]            done;
        logic [3:0]                     last_chan;
    } dmx_core_type;

    dmx_core_type st;
    dmx_core_type next_st;

    logic [NUM_CHAN-1:0] new_req;
    logic [NUM_CHAN-1:0] clr_req;
    logic                xfer_done;
    logic                tgt_ok;
    logic                to_periph;
    logic [ADDR_W-1:0]   mem_addr;
    logic [ADDR_W-1:0]   mem_base;
    logic [DATA_W-1:0]   xfer_data;
    logic [FIFO_W-1:0]   push_entry;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic                fifo_out_ready;
    logic [FIFO_W-1:0]   fifo_out;
    logic                out_to_periph;
    logic                out_tgt_ok;

    // ------------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------------

    // Two channels on one source both see the same request bit
    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            new_req[i] = chan_enable[i] &&
                (periph_req[chan_request_select_reg[i]] ||
                 chan_force[i]);
        end
    end

    // ------------------------------------------------------------------
    // Active transfer: address and data selection
    // ------------------------------------------------------------------

    // Transfer stalls only while the FIFO is full
    assign xfer_done = st.act_valid && fifo_in_ready;
    assign to_periph = chan_to_periph[st.act_chan];
    assign tgt_ok    = target_known(chan_periph_target_addr[st.act_chan],
                                    to_periph);

    // Register indirect uses periph_ind_addr; otherwise first or second start, plus progress
    always_comb begin
        mem_base = chan_use_second[st.act_chan] ?
                   chan_mem_start_second[st.act_chan] :
                   chan_mem_start_first[st.act_chan];
        if (chan_periph_indirect[st.act_chan]) begin
            mem_addr = periph_ind_addr;
        end else begin
            mem_addr = mem_base +
                ADDR_W'({st.count[st.act_chan], 1'b0});
        end
    end

    // Reads from an unknown target return zero
    always_comb begin
        if (to_periph) begin
            xfer_data = sram_rdata;
        end else if (tgt_ok) begin
            xfer_data = periph_rdata;
        end else begin
            xfer_data = '0;
        end
        push_entry                            = '0;
        push_entry[FE_OK_BIT]                 = tgt_ok;
        push_entry[FE_DIR_BIT]                = to_periph;
        push_entry[FE_ADDR_LSB +: ADDR_W]     = to_periph ?
            chan_periph_target_addr[st.act_chan] : mem_addr;
        push_entry[FE_DATA_LSB +: DATA_W]     = xfer_data;
    end

    // Read strobes are only raised in the transfer cycle itself
    assign xfer_active    = st.act_valid;
    assign xfer_chan      = st.act_chan;
    assign xfer_source    = chan_request_select_reg[st.act_chan];
    assign periph_rd_en   = xfer_done && !to_periph && tgt_ok;
    assign periph_rd_addr = chan_periph_target_addr[st.act_chan];
    assign sram_rd_en     = xfer_done && to_periph;
    assign sram_rd_addr   = mem_addr;

    // ------------------------------------------------------------------
    // Arbitration, pending latches and counters
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.done = '0;
        clr_req = '0;
        if (xfer_done) begin
            clr_req[st.act_chan] = 1'b1;
        end
        // A new request in the clearing cycle is kept: set wins
        next_st.pend = ((st.pend & ~clr_req) | new_req)
                       & chan_enable;
        // Progress and completion for the finishing channel
        if (xfer_done) begin
            next_st.last_chan = {1'b0, st.act_chan};
            if (st.count[st.act_chan] + 1'b1 ==
                chan_count_limit[st.act_chan]) begin
                next_st.count[st.act_chan] = '0;
                next_st.done[st.act_chan]  = 1'b1;
            end else begin
                next_st.count[st.act_chan] =
                    st.count[st.act_chan] + 1'b1;
            end
        end
        // Disabled channels restart from the first word
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (!chan_enable[i]) begin
                next_st.count[i] = '0;
            end
        end
        // Grant overlaps the running transfer, so no idle cycle
        if (!st.act_valid || xfer_done) begin
            next_st.act_valid = |next_st.pend;
            next_st.act_chan  = first_set(next_st.pend);
        end
    end

    // Reset drops every pending request and all progress
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st           <= '0;
            st.last_chan <= LAST_CHAN_NONE;
        end else begin
            st <= next_st;
        end
    end

    assign chan_transfer_count_reg   = st.count;
    assign chan_done_irq             = st.done;
    assign last_active_channel_field = st.last_chan;
    assign chan_pending              = st.pend;

    // ------------------------------------------------------------------
    // Write path: FIFO decouples the write ports from the transfer
    // ------------------------------------------------------------------

    // Buffering lets a slow write port absorb bursts without losing data
    dmx_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .in_valid  (xfer_done),
        .in_ready  (fifo_in_ready),
        .in_data   (push_entry),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out)
    );

    assign out_to_periph = fifo_out[FE_DIR_BIT];
    assign out_tgt_ok    = fifo_out[FE_OK_BIT];

    // Writes to an unknown target are drained without a strobe
    always_comb begin
        if (out_to_periph) begin
            fifo_out_ready = periph_wr_ready || !out_tgt_ok;
        end else begin
            fifo_out_ready = sram_wr_ready;
        end
    end

    assign periph_wr_en   = fifo_out_valid && out_to_periph
                            && out_tgt_ok;
    assign periph_wr_addr = fifo_out[FE_ADDR_LSB +: ADDR_W];
    assign periph_wdata   = fifo_out[FE_DATA_LSB +: DATA_W];
    assign sram_wr_en     = fifo_out_valid && !out_to_periph;
    assign sram_wr_addr   = fifo_out[FE_ADDR_LSB +: ADDR_W];
    assign sram_wdata     = fifo_out[FE_DATA_LSB +: DATA_W];

endmodule

// ### logic/dmx_pkg.sv
// Purpose: Shared constants for the multi-channel transfer core.
// Assumes: One system clock, eight channels, 16-bit words.
// Notes:   Source codes and target addresses name the DMA-ready map.
package dmx_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CHAN   = 8;
    localparam int CHAN_W     = 3;
    localparam int SRC_W      = 7;
    localparam int NUM_SRC    = 128;
    localparam int ADDR_W     = 16;
    localparam int DATA_W     = 16;
    localparam int CNT_W      = 10;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W     = 34;

    // Fifo entry layout: {target_ok, to_periph, dest_addr, data}
    localparam int FE_DATA_LSB = 0;
    localparam int FE_ADDR_LSB = 16;
    localparam int FE_DIR_BIT  = 32;
    localparam int FE_OK_BIT   = 33;

    localparam logic [3:0] LAST_CHAN_NONE = 4'hF;

    // ------------------------------------------------------------------
    // Request source codes
    // ------------------------------------------------------------------
    localparam logic [6:0] SRC_EXTERNAL_IRQ_ZERO = 7'h00;
    localparam logic [6:0] SRC_TIMER_TWO         = 7'h07;
    localparam logic [6:0] SRC_TIMER_THREE       = 7'h08;
    localparam logic [6:0] SRC_CAPTURE_ONE       = 7'h01;
    localparam logic [6:0] SRC_CAPTURE_TWO       = 7'h05;
    localparam logic [6:0] SRC_COMPARE_ONE       = 7'h02;
    localparam logic [6:0] SRC_COMPARE_TWO       = 7'h06;
    localparam logic [6:0] SRC_SERIAL_ONE        = 7'h0A;
    localparam logic [6:0] SRC_SERIAL_TWO        = 7'h21;
    localparam logic [6:0] SRC_UART_ONE_RX       = 7'h0B;
    localparam logic [6:0] SRC_UART_ONE_TX       = 7'h0C;
    localparam logic [6:0] SRC_UART_TWO_RX       = 7'h1E;
    localparam logic [6:0] SRC_UART_TWO_TX       = 7'h1F;
    localparam logic [6:0] SRC_CAN_RX_READY      = 7'h22;
    localparam logic [6:0] SRC_CAN_TX_REQUEST    = 7'h46;
    localparam logic [6:0] SRC_CODEC_INTERFACE   = 7'h3C;
    localparam logic [6:0] SRC_CONVERTER_DONE    = 7'h0D;
    localparam logic [6:0] SRC_PARALLEL_MASTER   = 7'h2D;
    localparam logic [6:0] SRC_DAC_RIGHT         = 7'h4E;
    localparam logic [6:0] SRC_DAC_LEFT          = 7'h4F;

    // ------------------------------------------------------------------
    // Peripheral target addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] TGT_CAPTURE_ONE   = 16'h0140;
    localparam logic [15:0] TGT_CAPTURE_TWO   = 16'h0144;
    localparam logic [15:0] TGT_COMPARE_ONE_S = 16'h0180;
    localparam logic [15:0] TGT_COMPARE_ONE_P = 16'h0182;
    localparam logic [15:0] TGT_COMPARE_TWO_S = 16'h0186;
    localparam logic [15:0] TGT_COMPARE_TWO_P = 16'h0188;
    localparam logic [15:0] TGT_UART_ONE_TX   = 16'h0224;
    localparam logic [15:0] TGT_UART_ONE_RX   = 16'h0226;
    localparam logic [15:0] TGT_UART_TWO_TX   = 16'h0234;
    localparam logic [15:0] TGT_UART_TWO_RX   = 16'h0236;
    localparam logic [15:0] TGT_SERIAL_ONE    = 16'h0248;
    localparam logic [15:0] TGT_SERIAL_TWO    = 16'h0268;
    localparam logic [15:0] TGT_CODEC_RX      = 16'h0290;
    localparam logic [15:0] TGT_CODEC_TX      = 16'h0298;
    localparam logic [15:0] TGT_CONVERTER     = 16'h0300;
    localparam logic [15:0] TGT_DAC_RIGHT     = 16'h03F6;
    localparam logic [15:0] TGT_DAC_LEFT      = 16'h03F8;
    localparam logic [15:0] TGT_CAN_RX        = 16'h0440;
    localparam logic [15:0] TGT_CAN_TX        = 16'h0442;
    localparam logic [15:0] TGT_PARALLEL      = 16'h0608;

endpackage

// ### logic/dmx_fifo.sv
// Purpose: Word FIFO between the transfer cycle and the write port.
// Assumes: Push and pop on one clock.
// Notes:   Read data come from a register stage in front of the array.
`timescale 1ns/1ps
module dmx_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [PW:0]                 used;
        logic                        hold_valid;
        logic [WIDTH-1:0]            hold;
    } dmx_fifo_type;

    dmx_fifo_type st;
    dmx_fifo_type next_st;
    logic         push;
    logic         pop;

    // ------------------------------------------------------------------
    // Next state: array write, then refill of the output register
    // ------------------------------------------------------------------
    always_comb begin
        next_st  = st;
        in_ready = (st.used != (PW+1)'(DEPTH));
        push     = in_valid && in_ready;
        pop      = (st.used != '0) && (!st.hold_valid || out_ready);
        if (push) begin
            next_st.mem[st.wr_ptr] = in_data;
            next_st.wr_ptr         = st.wr_ptr + 1'b1;
        end
        if (out_ready) begin
            next_st.hold_valid = 1'b0;
        end
        // Refill from the array; the drain side may stall indefinitely
        if (pop) begin
            next_st.hold       = st.mem[st.rd_ptr];
            next_st.hold_valid = 1'b1;
            next_st.rd_ptr     = st.rd_ptr + 1'b1;
        end
        next_st.used = st.used + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign out_valid = st.hold_valid;
    assign out_data  = st.hold;

endmodule

// ### verification/dmx_asserts.sv
// Purpose: Port checks for the transfer core.
// Assumes: One clock domain; bound to every dmx_core.
// Notes:   Priority order is judged by the bench.
`timescale 1ns/1ps
module dmx_asserts
    import dmx_pkg::*;
(
    input wire logic                            sys_clk,
    input wire logic                            nrst,
    input wire logic [NUM_CHAN-1:0]             chan_enable,
    input wire logic [NUM_CHAN-1:0][ADDR_W-1:0] chan_periph_target_addr,
    input wire logic                            xfer_active,
    input wire logic [CHAN_W-1:0]               xfer_chan,
    input wire logic                            periph_rd_en,
    input wire logic [ADDR_W-1:0]               periph_rd_addr,
    input wire logic                            sram_rd_en,
    input wire logic [NUM_CHAN-1:0][CNT_W-1:0]  chan_transfer_count_reg,
    input wire logic [NUM_CHAN-1:0]             chan_done_irq,
    input wire logic [3:0]                      last_active_channel_field,
    input wire logic [NUM_CHAN-1:0]             chan_pending
);
    // One domain for every check
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    grant_strobe_a: assert property (
        (periph_rd_en || sram_rd_en) |-> xfer_active) else $error("no grant");
    one_read_a: assert property (
        periph_rd_en |-> !sram_rd_en) else $error("two reads at once");
    rd_target_a: assert property (
        periph_rd_en |-> periph_rd_addr == chan_periph_target_addr[xfer_chan])
        else $error("bad read address");
    last_chan_a: assert property (
        (periph_rd_en || sram_rd_en) |=>
        last_active_channel_field == {1'b0, $past(xfer_chan)})
        else $error("stale last channel");
    pend_hold_a: assert property (
        chan_enable[3] && chan_pending[3] && !(xfer_active && xfer_chan == 3'h3)
        |=> chan_pending[3]) else $error("pending lost");
    irq_single_a: assert property (
        $onehot0(chan_done_irq)) else $error("several done pulses");
    irq_count_a: assert property (
        chan_done_irq[0] |-> chan_transfer_count_reg[0] == '0)
        else $error("count not zero at done");
    count_step_a: assert property (
        (periph_rd_en || sram_rd_en) && xfer_chan == 3'h0
        && chan_transfer_count_reg[0] == '0
        |-> ##1 chan_transfer_count_reg[0] == 10'h001 or ##[1:2] chan_done_irq[0])
        else $error("count did not step");
    cover property (periph_rd_en);
    cover property (sram_rd_en);
    cover property (|chan_done_irq);
endmodule
bind dmx_core dmx_asserts dmx_asserts_inst (.*);

// ### verification/dmx_far_model.sv
// Purpose: Peripheral bank and dual-port SRAM beside the core.
// Assumes: Reads answer in the strobe cycle.
// Notes:   Idle read buses show inverted data.
`timescale 1ns/1ps
module dmx_far_model (
    input  wire logic        sys_clk,
    input  wire logic        stall,
    input  wire logic        periph_rd_en,
    input  wire logic [15:0] periph_rd_addr,
    output logic      [15:0] periph_rdata,
    input  wire logic        sram_rd_en,
    input  wire logic [15:0] sram_rd_addr,
    output logic      [15:0] sram_rdata,
    input  wire logic        periph_wr_en,
    input  wire logic [15:0] periph_wr_addr,
    input  wire logic [15:0] periph_wdata,
    output logic             periph_wr_ready,
    input  wire logic        sram_wr_en,
    input  wire logic [15:0] sram_wr_addr,
    input  wire logic [15:0] sram_wdata,
    output logic             sram_wr_ready
);
    logic [15:0] sram [256];
    logic [15:0] plast_a, plast_d, pv, sv;
    int          n_swr = 0, n_pwr = 0;
    // Nonzero preload makes a zero read stand out
    initial for (int i = 0; i < 256; i++) sram[i] = {8'h5A, i[7:0]};
    assign pv = {periph_rd_addr[7:0], ~periph_rd_addr[15:8]};
    assign sv = sram[sram_rd_addr[8:1]];
    assign periph_rdata = periph_rd_en ? pv : ~pv;
    assign sram_rdata = sram_rd_en ? sv : ~sv;
    assign periph_wr_ready = !stall;
    assign sram_wr_ready = !stall;
    // Writes land only on an accepted cycle
    always @(posedge sys_clk) begin
        if (sram_wr_en && sram_wr_ready) begin
            sram[sram_wr_addr[8:1]] <= sram_wdata;
            n_swr <= n_swr + 1;
        end
        if (periph_wr_en && periph_wr_ready) begin
            plast_a <= periph_wr_addr;
            plast_d <= periph_wdata;
            n_pwr <= n_pwr + 1;
        end
    end
endmodule

// ### verification/dmx_core_bench.sv
// Purpose: Random and corner-case run of the transfer core.
// Assumes: Inputs change at falling edges; far side is the model.
// Notes:   Fixed waits cover the transfer walk with margin.
`timescale 1ns/1ps
module dmx_core_bench
    import dmx_pkg::*;
;
    logic sys_clk = 1'b0, nrst = 1'b0, stall = 1'b0;
    logic [7:0] chan_enable = '0, chan_to_periph = '0, chan_force = '0;
    logic [7:0] chan_periph_indirect = '0, chan_use_second = '0;
    logic [7:0][6:0] chan_request_select_reg = '0;
    logic [7:0][15:0] chan_periph_target_addr = '0;
    logic [7:0][15:0] chan_mem_start_first = '0, chan_mem_start_second = '0;
    logic [7:0][9:0] chan_count_limit = '1, chan_transfer_count_reg;
    logic [127:0] periph_req = '0;
    logic [15:0] periph_ind_addr = '0, periph_rd_addr, sram_rd_addr, ea;
    logic [15:0] periph_wr_addr, sram_wr_addr, periph_rdata, sram_rdata;
    logic [15:0] periph_wdata, sram_wdata;
    logic xfer_active, periph_rd_en, sram_rd_en, periph_wr_en, sram_wr_en;
    logic periph_wr_ready, sram_wr_ready;
    logic [2:0] xfer_chan;
    logic [6:0] xfer_source;
    logic [7:0] chan_done_irq, chan_pending;
    logic [3:0] last_active_channel_field;
    logic [31:0] rs = 32'h83D0;
    int n_fail = 0, checked = 0, nirq = 0, cyc = 0, n0;
    localparam logic [6:0] CODES [20] = '{SRC_EXTERNAL_IRQ_ZERO,
        SRC_TIMER_TWO, SRC_TIMER_THREE, SRC_CAPTURE_ONE, SRC_CAPTURE_TWO,
        SRC_COMPARE_ONE, SRC_COMPARE_TWO, SRC_SERIAL_ONE, SRC_SERIAL_TWO,
        SRC_UART_ONE_RX, SRC_UART_ONE_TX, SRC_UART_TWO_RX, SRC_UART_TWO_TX,
        SRC_CAN_RX_READY, SRC_CAN_TX_REQUEST, SRC_CODEC_INTERFACE,
        SRC_CONVERTER_DONE, SRC_PARALLEL_MASTER, SRC_DAC_RIGHT, SRC_DAC_LEFT};
    localparam logic [15:0] TGTS [10] = '{TGT_CAPTURE_ONE, TGT_CAPTURE_TWO,
        TGT_UART_ONE_RX, TGT_UART_TWO_RX, TGT_CAN_RX, TGT_CODEC_RX,
        TGT_CONVERTER, TGT_PARALLEL, TGT_SERIAL_ONE, TGT_SERIAL_TWO};
    dmx_core dmx_core_inst (.*);
    dmx_far_model dmx_far_model_inst (.*);
    initial forever #5 sys_clk = ~sys_clk;
    // Count channel 0 done pulses; stop a hang
    always @(posedge sys_clk) begin
        nirq += (chan_done_irq[0] === 1'b1);
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // Word the model shows at a peripheral address
    function automatic logic [15:0] pval(input logic [15:0] a);
        return {a[7:0], ~a[15:8]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic pulse(input int c);
        @(negedge sys_clk) periph_req[c] = 1'b1;
        @(negedge sys_clk) periph_req[c] = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk) nrst = 1'b1;
        chk("last", last_active_channel_field, 4'hF);
        chk("pend", chan_pending, 8'h00);
        // Every source code, random bases, both address modes
        chan_enable = 8'h20;
        for (int i = 0; i < 20; i++) begin
            rs = xs(rs);
            chan_request_select_reg[5] = CODES[i];
            chan_periph_target_addr[5] = TGTS[i % 10];
            {chan_mem_start_first[5], chan_mem_start_second[5]} = rs;
            {chan_periph_indirect[5], chan_use_second[5]} = rs[1:0];
            periph_ind_addr = rs[23:8];
            ea = rs[1] ? rs[23:8] : (rs[0] ? rs[15:0] : rs[31:16]) + 16'(2 * i);
            pulse(CODES[i]);
            idle(8);
            chk("sram", dmx_far_model_inst.sram[ea[8:1]], pval(TGTS[i % 10]));
            chk("last", last_active_channel_field, 4'h5);
        end
        chk("cnt5", chan_transfer_count_reg[5], 10'd20);
        $display("test codes done");
        // One source shared by a read and a write channel
        chan_enable = 8'h0A;
        chan_request_select_reg[3:1] = {3{SRC_SERIAL_ONE}};
        chan_periph_target_addr[3:1] = {3{TGT_SERIAL_ONE}};
        chan_to_periph[1] = 1'b1;
        chan_mem_start_first[3:1] = {16'h0100, 16'h0000, 16'h0040};
        dmx_far_model_inst.sram[32] = 16'h5A20;
        pulse(SRC_SERIAL_ONE);
        chk("chan", xfer_chan, 3'h1);
        chk("src", xfer_source, SRC_SERIAL_ONE);
        idle(1);
        chk("last", last_active_channel_field, 4'h1);
        chk("pend3", chan_pending[3], 1'b1);
        idle(1);
        chk("last", last_active_channel_field, 4'h3);
        idle(8);
        chk("pwa", dmx_far_model_inst.plast_a, TGT_SERIAL_ONE);
        chk("pwd", dmx_far_model_inst.plast_d, 16'h5A20);
        chk("srw", dmx_far_model_inst.sram[128], pval(TGT_SERIAL_ONE));
        $display("test shared done");
        // Forced requests, block limit and unknown targets
        chan_enable = 8'h07;
        chan_count_limit[0] = 10'h002;
        chan_periph_target_addr = {80'h0, 32'h0100_0100, TGT_CONVERTER};
        chan_mem_start_first[2] = 16'h01C0;
        n0 = dmx_far_model_inst.n_pwr;
        repeat (2) begin
            @(negedge sys_clk) chan_force = 8'h07;
            @(negedge sys_clk) chan_force = 8'h00;
            idle(8);
        end
        chk("irq", nirq, 1);
        chk("cnt0", chan_transfer_count_reg[0], 10'h000);
        chk("last", last_active_channel_field, 4'h2);
        chk("zero", dmx_far_model_inst.sram[224], 16'h0000);
        chk("drop", dmx_far_model_inst.n_pwr, n0);
        $display("test force done");
        // Stall writes until the buffer refuses, then drain
        stall = 1'b1;
        chan_enable = 8'h40;
        chan_force = 8'h40;
        idle(30);
        chan_force = 8'h00;
        idle(2);
        chk("full", chan_transfer_count_reg[6], 10'd17);
        chk("pend6", chan_pending[6], 1'b1);
        n0 = dmx_far_model_inst.n_swr;
        stall = 1'b0;
        idle(40);
        chk("drain", dmx_far_model_inst.n_swr - n0, 18);
        $display("test fifo done");
        tally_and_finish();
    end
endmodule
